// ===== inc/gps_consts.vh
// Purpose: Shared constants for the general I/O port block with segment sharing
// Assumes: Byte-wide register port, one 100 MHz clock
// Notes:   Offsets are register indices on the plain register port
`ifndef GPS_CONSTS_VH
`define GPS_CONSTS_VH

// Register port geometry
`define GPS_ADDR_W          4
`define GPS_DATA_W          8
`define GPS_PIN_W           4

// Register offsets
`define GPS_OFS_P2_LATCH    4'h0
`define GPS_OFS_P2_DIR      4'h1
`define GPS_OFS_P2_PULL     4'h2
`define GPS_OFS_P4_LATCH    4'h3
`define GPS_OFS_P4_DIR      4'h4
`define GPS_OFS_STBY_CTL    4'h5
`define GPS_OFS_CMP_CTL     4'h6
`define GPS_OFS_SEG_SEL     4'h7
`define GPS_OFS_LCD_EN1     4'h8

// Reset values
`define GPS_RST_LATCH       4'h0
`define GPS_RST_DIR         4'h0
`define GPS_RST_PULL        4'h0
`define GPS_RST_SEG_SEL     4'h0
`define GPS_RST_BIT         1'b0
`define GPS_RST_CMP_DIS     1'b1
`define GPS_RST_CMP_EN      2'b00
`define GPS_RST_RDATA       8'h00

// Field positions
`define GPS_FLD_LOW         3:0
`define GPS_BIT_SPL         0
`define GPS_BIT_CMP_DIS     0
`define GPS_BIT_PORT_INPUT_CONTROL_BIT_EN    0

// Filler for unimplemented upper bits
`define GPS_ZERO_HI         4'h0
`define GPS_ZERO_BYTE       8'h00
`define GPS_ZERO_HI7        7'h00

`endif

// ===== core/gps_pad_ctl.v
// Purpose: Registered pad control for one four-pin port
// Assumes: Pin inputs synchronous to ref_clk
// Notes:   All outputs come from flip-flops, one cycle after their cause
`timescale 1ns/1ps
module gps_pad_ctl #(
  parameter W = 4
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         force_hiz,
  input  wire [W-1:0] dir,
  input  wire [W-1:0] latch,
  input  wire [W-1:0] alt_oe,
  input  wire [W-1:0] alt_out,
  input  wire [W-1:0] pull_sel,
  input  wire [W-1:0] in_en,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_out_q,
  output reg  [W-1:0] pin_oe_q,
  output reg  [W-1:0] pull_en_q,
  output reg  [W-1:0] in_gated_q
);

  reg [W-1:0] oe_d;
  reg [W-1:0] out_d;
  reg [W-1:0] pull_d;

  //////////////////////////////////////////////////////////////////////////
  // Drive selection: peripheral first, then port direction
  always @* begin
    out_d = (alt_oe & alt_out) | (~alt_oe & latch);
    oe_d  = alt_oe | dir;
    if (force_hiz) begin
      oe_d = {W{1'b0}};
    end
    // Pull-up drops out wherever the pad drives low
    pull_d = pull_sel & ~(oe_d & ~out_d);
  end

  //////////////////////////////////////////////////////////////////////////
  // Pad flops; input path held low while blocked
  always @(posedge ref_clk) begin
    if (rst) begin
      pin_out_q  <= {W{1'b0}};
      pin_oe_q   <= {W{1'b0}};
      pull_en_q  <= {W{1'b0}};
      in_gated_q <= {W{1'b0}};
    end else begin
      pin_out_q  <= out_d;
      pin_oe_q   <= oe_d;
      pull_en_q  <= pull_d;
      in_gated_q <= force_hiz ? {W{1'b0}} : (pin_in & in_en);
    end
  end

endmodule

// ===== core/gps_port.v
// Purpose: Two four-pin general I/O ports, one shared with comparator/peripherals,
//          one shared with LCD segment outputs
// Assumes: Synchronous active-high reset, byte register port, reads answered next cycle
// Notes:   Upper four bits of every port register are unimplemented and read zero
//
// Notes on behaviour
// - Direction bit 1 makes the pin an output driving its data latch.
// - Direction bit 0 makes the pin an input; latch is not driven.
// - Output pin level equals its data latch bit.
// - Data writes always update the latch; only outputs show it at once.
// - Data reads of output pins return the latch.
// - Input pins read the pin level, but read-modify-write reads return the latch.
// - Enabled peripheral output drives pin; reads give pin, read-modify-write latch.
// - Reads give pin level even when a peripheral uses it as input.
// - Reset clears all direction bits so every pin is an input; first-port pins still drive wherever p2_periph_oe is set.
// - Standby bit 1 in stop/watch forces high impedance, input blocked low.
// - Standby bit 0 leaves pin state and output level unchanged in stop/watch.
// - Pull-up select 1 connects pull-up, except while the pin drives low.
// - Comparator input enabled when its disable bit is 0, disabled when 1.
// - First port register bits 0..3 map to pins 0..3; upper bits unimplemented.
// - Segment port bits 0..3 map to pins 0..3; upper bits unimplemented.
`timescale 1ns/1ps
`include "gps_consts.vh"
module gps_port #(
  parameter PW = `GPS_PIN_W
) (
  input  wire                   ref_clk,
  input  wire                   rst,
  // Register port
  input  wire [`GPS_ADDR_W-1:0] reg_addr,
  input  wire [`GPS_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  input  wire                   reg_rmw,
  output reg  [`GPS_DATA_W-1:0] reg_rdata_q,
  // Chip standby state: stop or watch mode active
  input  wire                   standby_active,
  // First port pins and shared peripherals
  input  wire [PW-1:0]          p2_pin_in,
  output wire [PW-1:0]          p2_pin_out,
  output wire [PW-1:0]          p2_pin_oe,
  output wire [PW-1:0]          p2_pullup_en,
  input  wire [PW-1:0]          p2_periph_oe,
  input  wire [PW-1:0]          p2_periph_out,
  output wire [PW-1:0]          p2_periph_in,
  output reg  [1:0]             cmp_input_en_q,
  // Segment-shared port pins
  input  wire [PW-1:0]          p4_pin_in,
  output wire [PW-1:0]          p4_pin_out,
  output wire [PW-1:0]          p4_pin_oe,
  output wire [PW-1:0]          p4_periph_in,
  input  wire [PW-1:0]          lcd_seg_drive,
  input  wire [PW-1:0]          lcd_seg_level,
  output reg  [PW-1:0]          p4_seg_mode_q
);

  //////////////////////////////////////////////////////////////////////////
  // Register state
  reg  [PW-1:0] p2_latch_q;
  reg  [PW-1:0] p2_dir_q;
  reg  [PW-1:0] p2_pull_q;
  reg  [PW-1:0] p4_latch_q;
  reg  [PW-1:0] p4_dir_q;
  reg  [PW-1:0] seg_sel_q;
  reg           spl_q;
  reg           cmp_dis_q;
  reg           port_input_control_bit_q;

  reg  [`GPS_DATA_W-1:0] rdata_d;
  wire                   force_hiz;
  wire [PW-1:0]          p4_port_en;
  wire [PW-1:0]          p4_alt_oe;
  wire [PW-1:0]          p2_in_en;

  //////////////////////////////////////////////////////////////////////////
  // Helper: pin value seen by a data read
  function [PW-1:0] port_read;
    input [PW-1:0] latch;
    input [PW-1:0] dir;
    input [PW-1:0] alt_oe;
    input [PW-1:0] pin;
    input          read_modify_write_access;
    begin
      if (read_modify_write_access) begin
        port_read = latch;
      end else begin
        // Output pins read the latch, unless a peripheral owns the drive
        port_read = (dir & ~alt_oe & latch) | (~(dir & ~alt_oe) & pin);
      end
    end
  endfunction

  // Helper: widen a four-bit field to a byte, upper bits zero
  function [`GPS_DATA_W-1:0] to_byte;
    input [PW-1:0] v;
    begin
      to_byte = {`GPS_ZERO_HI, v};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register writes; upper data bits are dropped
  always @(posedge ref_clk) begin
    if (rst) begin
      p2_latch_q <= `GPS_RST_LATCH;
      p2_dir_q   <= `GPS_RST_DIR;
      p2_pull_q  <= `GPS_RST_PULL;
      p4_latch_q <= `GPS_RST_LATCH;
      p4_dir_q   <= `GPS_RST_DIR;
      seg_sel_q  <= `GPS_RST_SEG_SEL;
      spl_q      <= `GPS_RST_BIT;
      cmp_dis_q  <= `GPS_RST_CMP_DIS;
      port_input_control_bit_q    <= `GPS_RST_BIT;
    end else if (reg_wr) begin
      case (reg_addr)
        `GPS_OFS_P2_LATCH: begin
          p2_latch_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_P2_DIR: begin
          p2_dir_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_P2_PULL: begin
          p2_pull_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_P4_LATCH: begin
          p4_latch_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_P4_DIR: begin
          p4_dir_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_STBY_CTL: begin
          spl_q <= reg_wdata[`GPS_BIT_SPL];
        end
        `GPS_OFS_CMP_CTL: begin
          cmp_dis_q <= reg_wdata[`GPS_BIT_CMP_DIS];
        end
        `GPS_OFS_SEG_SEL: begin
          seg_sel_q <= reg_wdata[`GPS_FLD_LOW];
        end
        `GPS_OFS_LCD_EN1: begin
          port_input_control_bit_q <= reg_wdata[`GPS_BIT_PORT_INPUT_CONTROL_BIT_EN];
        end
        default: begin
          p2_latch_q <= p2_latch_q;
        end
      endcase
    end
  end

  // Blocked input reads low in forced standby, like the peripheral path
  function [PW-1:0] p2_periph_in_raw;
    input [PW-1:0] pin;
    begin
      p2_periph_in_raw = force_hiz ? {PW{1'b0}} : pin;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Read mux; the qualifier picks latch over pin on data registers
  always @* begin
    rdata_d = `GPS_ZERO_BYTE;
    case (reg_addr)
      `GPS_OFS_P2_LATCH: begin
        rdata_d = to_byte(port_read(p2_latch_q, p2_dir_q, p2_periph_oe,
                                    p2_periph_in_raw(p2_pin_in), reg_rmw));
      end
      `GPS_OFS_P2_DIR: begin
        rdata_d = to_byte(p2_dir_q);
      end
      `GPS_OFS_P2_PULL: begin
        rdata_d = to_byte(p2_pull_q);
      end
      `GPS_OFS_P4_LATCH: begin
        rdata_d = to_byte(port_read(p4_latch_q, p4_dir_q, p4_alt_oe,
                                    p4_pin_in & p4_port_en & {PW{~force_hiz}},
                                    reg_rmw));
      end
      `GPS_OFS_P4_DIR: begin
        rdata_d = to_byte(p4_dir_q);
      end
      `GPS_OFS_STBY_CTL: begin
        rdata_d = {`GPS_ZERO_HI7, spl_q};
      end
      `GPS_OFS_CMP_CTL: begin
        rdata_d = {`GPS_ZERO_HI7, cmp_dis_q};
      end
      `GPS_OFS_SEG_SEL: begin
        rdata_d = to_byte(seg_sel_q);
      end
      `GPS_OFS_LCD_EN1: begin
        rdata_d = {`GPS_ZERO_HI7, port_input_control_bit_q};
      end
      default: begin
        rdata_d = `GPS_ZERO_BYTE;                               // Unmapped reads zero
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= `GPS_RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= `GPS_RST_RDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Standby forcing; with the bit clear the pads keep their state
  assign force_hiz = spl_q & standby_active;

  // Segment sharing: port input control opens the selected function
  assign p4_port_en = {PW{port_input_control_bit_q}} & ~seg_sel_q;
  assign p4_alt_oe  = {PW{port_input_control_bit_q}} & seg_sel_q & lcd_seg_drive;
  assign p2_in_en   = {PW{1'b1}};

  //////////////////////////////////////////////////////////////////////////
  // Comparator input gate, independent of data and direction
  always @(posedge ref_clk) begin
    if (rst) begin
      cmp_input_en_q <= `GPS_RST_CMP_EN;
      p4_seg_mode_q  <= `GPS_RST_SEG_SEL;
    end else begin
      cmp_input_en_q <= {2{~cmp_dis_q}};
      p4_seg_mode_q  <= {PW{port_input_control_bit_q}} & seg_sel_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // First port pads, with pull-ups and shared peripheral drive
  gps_pad_ctl #(
    .W (PW)
  ) u_p2_pads (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .force_hiz  (force_hiz),
    .dir        (p2_dir_q),
    .latch      (p2_latch_q),
    .alt_oe     (p2_periph_oe),
    .alt_out    (p2_periph_out),
    .pull_sel   (p2_pull_q),
    .in_en      (p2_in_en),
    .pin_in     (p2_pin_in),
    .pin_out_q  (p2_pin_out),
    .pin_oe_q   (p2_pin_oe),
    .pull_en_q  (p2_pullup_en),
    .in_gated_q (p2_periph_in)
  );

  // Segment port pads; no pull-up on this port, direction only while port-owned
  gps_pad_ctl #(
    .W (PW)
  ) u_p4_pads (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .force_hiz  (force_hiz),
    .dir        (p4_dir_q & p4_port_en),
    .latch      (p4_latch_q),
    .alt_oe     (p4_alt_oe),
    .alt_out    (lcd_seg_level),
    .pull_sel   ({PW{1'b0}}),
    .in_en      (p4_port_en),
    .pin_in     (p4_pin_in),
    .pin_out_q  (p4_pin_out),
    .pin_oe_q   (p4_pin_oe),
    .pull_en_q  (),
    .in_gated_q (p4_periph_in)
  );

endmodule

// ===== dv/gps_port_sva.sv
// Purpose: Port-level assertions for gps_port
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only top-level ports; register state is inferred
`timescale 1ns/1ps
module gps_port_chk (
  input logic       ref_clk,
  input logic       rst,
  input logic       reg_rd,
  input logic       reg_rmw,
  input logic [7:0] reg_rdata_q,
  input logic [3:0] p2_pin_in,
  input logic [3:0] p2_pin_out,
  input logic [3:0] p2_pin_oe,
  input logic [3:0] p2_pullup_en,
  input logic [3:0] p2_periph_oe,
  input logic [3:0] p2_periph_out,
  input logic [3:0] p2_periph_in,
  input logic [1:0] cmp_input_en_q,
  input logic [3:0] p4_pin_in,
  input logic [3:0] p4_pin_out,
  input logic [3:0] p4_pin_oe,
  input logic [3:0] p4_periph_in,
  input logic [3:0] lcd_seg_drive,
  input logic [3:0] lcd_seg_level,
  input logic [3:0] p4_seg_mode_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Read data only in the slot after a read strobe
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_hi_zero; reg_rdata_q[7:4] == 4'h0; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits not zero");
  // Peripheral drive wins the pad
  property p_per_lvl; ((p2_pin_oe & $past(p2_periph_oe)) & (p2_pin_out ^ $past(p2_periph_out))) == 4'h0; endproperty
  a_per_lvl: assert property (p_per_lvl) else $error("peripheral level lost");
  // Pull-up must drop while driving low
  property p_pull_low; (p2_pullup_en & p2_pin_oe & ~p2_pin_out) == 4'h0; endproperty
  a_pull_low: assert property (p_pull_low) else $error("pull-up on low pad");
  // Gated inputs never show a high that the pad lacked
  property p_blk2; (p2_periph_in & ~$past(p2_pin_in)) == 4'h0; endproperty
  a_blk2: assert property (p_blk2) else $error("port two input not gated");
  property p_blk4; (p4_periph_in & ~$past(p4_pin_in)) == 4'h0; endproperty
  a_blk4: assert property (p_blk4) else $error("port four input not gated");
  // Segment pads carry only the LCD level
  property p_seg_lvl; (p4_pin_oe & p4_seg_mode_q & (p4_pin_out ^ $past(lcd_seg_level))) == 4'h0; endproperty
  a_seg_lvl: assert property (p_seg_lvl) else $error("segment level wrong");
  property p_seg_drv; (p4_pin_oe & p4_seg_mode_q & ~$past(lcd_seg_drive)) == 4'h0; endproperty
  a_seg_drv: assert property (p_seg_drv) else $error("segment pad driven idle");
  // After reset only first-port pads under peripheral drive may drive; all other pads are inputs and comparator is off
  property p_rst_in; $past(rst) |-> p4_pin_oe == 4'h0 && (p2_pin_oe & ~$past(p2_periph_oe)) == 4'h0; endproperty
  a_rst_in: assert property (p_rst_in) else $error("pad driven after reset");
  property p_cmp_rst; $past(rst) |-> cmp_input_en_q == 2'b00; endproperty
  a_cmp_rst: assert property (p_cmp_rst) else $error("comparator on after reset");
  ////////////////////////////////////////////////////////////////
  c_rmw: cover property (reg_rd && reg_rmw);
  c_seg: cover property (p4_seg_mode_q != 4'h0 && p4_pin_oe != 4'h0);
  c_pull: cover property (p2_pullup_en != 4'h0 && p2_pin_oe != 4'h0);
endmodule
bind gps_port gps_port_chk i_chk (.*);

// ===== dv/gps_pin_model.sv
// Purpose: Board side of one four-pin port
// Assumes: Board always drives undriven pins strongly
// Notes:   Pad drive beats the board level
`timescale 1ns/1ps
module gps_pin_model (
  input  wire [3:0] drv_out,
  input  wire [3:0] drv_oe,
  input  wire [3:0] ext_lvl,
  output wire [3:0] pin_lvl
);
  // Resolved wire level seen by the pad input
  assign pin_lvl = (drv_oe & drv_out) | (~drv_oe & ext_lvl);
endmodule

// ===== dv/gps_port_bench.sv
// Purpose: Self-checking bench for gps_port
// Assumes: Pads lag their cause by one edge
// Notes:   Random configurations with a fixed seed
`timescale 1ns/1ps
`include "gps_consts.vh"
module gps_port_bench;
  logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, read_modify_write_access = 1'b0, stb = 1'b0;
  logic [3:0] addr = 4'h0, poe = 4'h0, pout = 4'h0, e2 = 4'h0, e4 = 4'h0;
  logic [3:0] gdrv = 4'h0, glvl = 4'h0;
  logic [7:0] wdata = 8'h00;
  wire  [7:0] rdata;
  wire  [3:0] p2i, p2o, p2e, pu, p2pi, p4i, p4o, p4e, p4pi, seg;
  wire  [1:0] cmp;
  int fail_count = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////
  gps_port i_gps_port (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rmw(read_modify_write_access), .reg_rdata_q(rdata), .standby_active(stb),
    .p2_pin_in(p2i), .p2_pin_out(p2o), .p2_pin_oe(p2e), .p2_pullup_en(pu),
    .p2_periph_oe(poe), .p2_periph_out(pout), .p2_periph_in(p2pi), .cmp_input_en_q(cmp),
    .p4_pin_in(p4i), .p4_pin_out(p4o), .p4_pin_oe(p4e), .p4_periph_in(p4pi),
    .lcd_seg_drive(gdrv), .lcd_seg_level(glvl), .p4_seg_mode_q(seg));
  gps_pin_model i_pins2 (.drv_out(p2o), .drv_oe(p2e), .ext_lvl(e2), .pin_lvl(p2i));
  gps_pin_model i_pins4 (.drv_out(p4o), .drv_oe(p4e), .ext_lvl(e4), .pin_lvl(p4i));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes last one cycle; the gap keeps each signal to one driver step
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic m, input logic [7:0] e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    read_modify_write_access <= m;
    @(posedge ref_clk);
    rd <= 1'b0;
    read_modify_write_access <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #50000;
    fail_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] l2, d2, u2, l4, d4, s4, c;
    logic [3:0] o2, v2, n2, o4, v4, n4;
    logic sp, f;
    void'($urandom(32'h5cef));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("p2 dir", `GPS_OFS_P2_DIR, 1'b0, 8'h00);
    rd_chk("p4 dir", `GPS_OFS_P4_DIR, 1'b0, 8'h00);
    chk("cmp en", 8'h00, {6'h00, cmp});
    wr_reg(4'hf, 8'hff);
    rd_chk("unmapped", 4'hf, 1'b0, 8'h00);
    wr_reg(`GPS_OFS_LCD_EN1, 8'h01);
    $display("test reset done");
    // Random setups; first pass sets every first-port pin to output
    for (int i = 0; i < 24; i++) begin
      l2 = 8'($urandom);
      d2 = (i == 0) ? 8'hff : 8'($urandom);
      u2 = 8'($urandom);
      l4 = 8'($urandom);
      s4 = 8'($urandom) & 8'h0f;
      d4 = 8'($urandom) & ~s4;
      c = 8'($urandom);
      sp = 1'($urandom);
      wr_reg(`GPS_OFS_P2_LATCH, l2);
      wr_reg(`GPS_OFS_P2_DIR, d2);
      wr_reg(`GPS_OFS_P2_PULL, u2);
      wr_reg(`GPS_OFS_P4_LATCH, l4);
      wr_reg(`GPS_OFS_P4_DIR, d4);
      wr_reg(`GPS_OFS_SEG_SEL, s4);
      wr_reg(`GPS_OFS_STBY_CTL, {7'h00, sp});
      wr_reg(`GPS_OFS_CMP_CTL, c);
      @(posedge ref_clk);
      poe <= 4'($urandom) & ~d2[3:0];
      pout <= 4'($urandom);
      e2 <= 4'($urandom);
      e4 <= 4'($urandom);
      gdrv <= 4'($urandom);
      glvl <= 4'($urandom);
      stb <= (i > 1) ? 1'($urandom) : 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      f = sp & stb;
      o2 = f ? 4'h0 : (d2[3:0] | poe);
      v2 = (poe & pout) | (~poe & l2[3:0]);
      n2 = (o2 & v2) | (~o2 & e2);
      o4 = f ? 4'h0 : (d4[3:0] | (s4[3:0] & gdrv));
      v4 = (s4[3:0] & glvl) | (~s4[3:0] & l4[3:0]);
      n4 = (o4 & v4) | (~o4 & e4);
      chk("p2 oe", {4'h0, o2}, {4'h0, p2e});
      chk("p2 out", {4'h0, o2 & v2}, {4'h0, p2e & p2o});
      chk("pull", {4'h0, u2[3:0] & ~(o2 & ~v2)}, {4'h0, pu});
      chk("p2 gated in", {4'h0, f ? 4'h0 : n2}, {4'h0, p2pi});
      chk("p4 oe", {4'h0, o4}, {4'h0, p4e});
      chk("p4 out", {4'h0, o4 & v4}, {4'h0, p4e & p4o});
      chk("seg mode", s4, {4'h0, seg});
      chk("p4 gated in", {4'h0, f ? 4'h0 : (n4 & ~s4[3:0])}, {4'h0, p4pi});
      chk("cmp en", {6'h00, ~c[0], ~c[0]}, {6'h00, cmp});
      rd_chk("p2 rd", `GPS_OFS_P2_LATCH, 1'b0, {4'h0, (l2[3:0] & d2[3:0] & ~poe) |
        (f ? 4'h0 : n2 & ~(d2[3:0] & ~poe))});
      rd_chk("p2 rmw", `GPS_OFS_P2_LATCH, 1'b1, {4'h0, l2[3:0]});
      rd_chk("p4 rd", `GPS_OFS_P4_LATCH, 1'b0, {4'h0, (l4[3:0] & d4[3:0]) |
        (f ? 4'h0 : e4 & ~d4[3:0] & ~s4[3:0])});
      rd_chk("p4 rmw", `GPS_OFS_P4_LATCH, 1'b1, {4'h0, l4[3:0]});
      rd_chk("p2 dir rd", `GPS_OFS_P2_DIR, 1'b0, {4'h0, d2[3:0]});
      rd_chk("p2 pull rd", `GPS_OFS_P2_PULL, 1'b0, {4'h0, u2[3:0]});
      rd_chk("p4 dir rd", `GPS_OFS_P4_DIR, 1'b0, {4'h0, d4[3:0]});
      rd_chk("seg sel rd", `GPS_OFS_SEG_SEL, 1'b0, s4);
      rd_chk("stby rd", `GPS_OFS_STBY_CTL, 1'b0, {7'h00, sp});
      rd_chk("cmp rd", `GPS_OFS_CMP_CTL, 1'b0, {7'h00, c[0]});
    end
    $display("test random done");
    // Port input control off: segment port neither port-driven nor segment-driven
    wr_reg(`GPS_OFS_LCD_EN1, 8'h00);
    wr_reg(`GPS_OFS_P4_DIR, 8'h0f);
    repeat (2) @(posedge ref_clk);
    #1 chk("p4 oe off", 8'h00, {4'h0, p4e});
    chk("seg off", 8'h00, {4'h0, seg});
    rd_chk("port_input_control_bit rd", `GPS_OFS_LCD_EN1, 1'b0, 8'h00);
    $display("test port_input_control_bit off done");
    finish_test();
  end
endmodule
